// ### hw/ejs_consts.svh
// register offsets, field positions, reset values and timing of the event jump sequencer
`ifndef EJS_CONSTS_SVH
`define EJS_CONSTS_SVH
`define EJS_OFS_CTRL   8'h00
`define EJS_OFS_STAT   8'h04
`define EJS_OFS_MASK   8'h08
`define EJS_OFS_STATE  8'h0c
`define EJS_OFS_TADDR  8'h10
`define EJS_OFS_D0     8'h14
`define EJS_OFS_D1     8'h18
`define EJS_OFS_D2     8'h1c
`define EJS_OFS_E0     8'h20
`define EJS_OFS_E1     8'h24
`define EJS_OFS_COMMIT 8'h28
`define EJS_CTRL_GO    0
`define EJS_CTRL_STEP  1
`define EJS_CTRL_HALT  2
`define EJS_CTRL_ENT   15:8
`define EJS_CMT_ENT    0
`define EJS_CMT_EV     1
`define EJS_IRQ_LO     0
`define EJS_IRQ_HI     1
`define EJS_IRQ_STOP   2
`define EJS_D2_RST     24'h7e0ffc
`define EJS_E0_RST     20'h00400
`define EJS_E1_RST     32'h0000_0000
`define EJS_NX_STOP    9'h100
`define EJS_NX_P2      9'h1fe
`define EJS_NX_P1      9'h1ff
`define EJS_MS_NS      1000000
`define EJS_CLK_NS     10
`define EJS_MS_CYC     (`EJS_MS_NS / `EJS_CLK_NS)
`endif

// ### hw/ejs_pkg.sv
// types of the event jump sequencer
package ejs_pkg;
    typedef logic signed [22:0] ejs_trav_t;
    typedef enum logic [1:0] {
        L_NONE = 2'b00, L_MANUAL = 2'b01, L_AUTO = 2'b10, L_CONT = 2'b11
    } ejs_link_e;
    typedef enum logic [3:0] {
        T_OFF = 4'h0, T_ON_CALC = 4'h1, T_ON_MS = 4'h2, T_OFF_CALC = 4'h3,
        T_OFF_MS = 4'h4, T_ON_EDGE = 4'h5, T_OFF_EDGE = 4'h6,
        T_ON_CUM = 4'h7, T_OFF_CUM = 4'h8
    } ejs_typ_e;
    typedef enum logic [2:0] {
        S_IDLE = 3'b000, S_FETCH = 3'b001, S_LDLO = 3'b010, S_LDHI = 3'b011,
        S_ARM = 3'b100, S_RUN = 3'b101, S_DWELL = 3'b110, S_WAIT = 3'b111
    } ejs_state_e;
    typedef struct packed {
        logic        incr;
        logic [5:0]  hi;
        logic [5:0]  lo;
        logic [8:0]  next;
        ejs_link_e   link;
        ejs_trav_t   off;
        ejs_trav_t   base;
    } ejs_ent_s;
    typedef struct packed {
        logic [15:0] count;
        logic [15:0] dwell;
        ejs_typ_e    typ;
        logic [4:0]  sel;
        logic [8:0]  next;
        ejs_link_e   link;
    } ejs_rec_s;
endpackage

// ### hw/ejs_mem_if.sv
// table memory port between sequencer and its storage
`timescale 1ns/1ps
`default_nettype none
interface ejs_mem_if #(parameter int DW = 8, parameter int AW = 4);
    logic          we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;
    modport host (output we, waddr, wdata, raddr, input rdata);
    modport mem  (input we, waddr, wdata, raddr, output rdata);
endinterface
`default_nettype wire

// ### hw/ejs_mem.sv
// single-port-write table memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module ejs_mem #(
    parameter int DW = 8, // word width
    parameter int AW = 4  // address width
) (
    input wire logic clk_in, // clock
    ejs_mem_if.mem   bus     // table port
);
    logic [DW-1:0] ram [2**AW];

    always_ff @(posedge clk_in)
    begin
        if (bus.we)
        begin
            ram[bus.waddr] <= bus.wdata;
        end
        bus.rdata <= ram[bus.raddr];
    end
endmodule
`default_nettype wire

// ### hw/ejs_top.sv
// event jump sequencer: steps the operation table and branches on io events
// Overview of operation
// - incremental entries in a loop add offset times pass count to travel
// - branching follows on/off state of the event's selected io signal
// - armed event fired during link or loop aborts entry, jumps to successor
// - each entry holds a low and a high event selection
// - low and high firing together: high event is taken
// - selection -1 disables, 0..31 picks record; low resets 1, high -1
// - record link mode: none, manual, automatic, continuous; reset none
// - successor: -256 stop, -2 skip one, -1 next, 0..255 absolute
// - after firing wait dwell in milliseconds before proceeding
// - record selects trigger signal; zero means unused, never fires
// - trigger type codes: off, ms, cumulative, edges; reset off
// - count gives milliseconds for time types, detections for edge types
// - cumulative types 7 and 8 exist only in newer revisions
// - without firing, entry completes and own link picks successor
// - an entry with no link stops sequencing there when it completes, even in a loop
`timescale 1ns/1ps
`default_nettype none
`include "ejs_consts.svh"
module ejs_top #(
    parameter int unsigned MS_CYC    = `EJS_MS_CYC, // clock cycles per millisecond
    parameter bit          HAS_CUMUL = 1'b1         // types 7 and 8 present
) (
    input  wire logic        ref_clk_in,      // 100 MHz clock
    input  wire logic        rstn_in,         // async reset, active low
    input  wire logic [7:0]  addr_in,         // register byte address
    input  wire logic [31:0] wdata_in,        // register write data
    input  wire logic        we_in,           // write strobe
    input  wire logic        re_in,           // read strobe
    output logic [31:0]      rdata_out,       // read data, cycle after strobe
    input  wire logic [31:0] io_in,           // io signals, bit 0 unused
    input  wire logic        entry_done_in,   // motion core finished entry
    input  wire logic        in_loop_in,      // loop logic: inside a loop
    input  wire logic [7:0]  loop_iter_in,    // loop passes completed
    output logic [7:0]       entry_no_out,    // current entry index
    output logic             entry_start_out, // pulse: start entry
    output logic             abort_out,       // pulse: abandon entry
    output var ejs_pkg::ejs_trav_t travel_out, // commanded travel
    output logic             running_out,     // sequencer busy
    output logic             irq_out          // level interrupt
);
    import ejs_pkg::*;

    logic [31:0] io_s1_q;
    logic [31:0] io_s2_q;
    logic [7:0]  start_ent_q;
    logic [2:0]  stat_q;
    logic [2:0]  mask_q;
    logic [7:0]  taddr_q;
    logic [22:0] d0_q;
    logic [22:0] d1_q;
    logic [23:0] d2_q;
    logic [19:0] e0_q;
    logic [31:0] e1_q;
    logic [31:0] ev_valid_q;
    logic [31:0] rdata_q;
    logic [31:0] rd_mux;
    ejs_state_e  state_q;
    ejs_state_e  state_d;
    logic [7:0]  cur_q;
    logic [7:0]  cur_d;
    ejs_link_e   plink_q;
    ejs_link_e   plink_d;
    logic [8:0]  pnext_q;
    logic [8:0]  pnext_d;
    logic [15:0] dwell_q;
    logic [15:0] dwell_d;
    logic        start_q;
    logic        start_d;
    logic        abort_q;
    logic        abort_d;
    logic        stop_ev;
    logic [16:0] tick_cnt_q;
    logic        was_run_q;
    ejs_ent_s    ent_q;
    ejs_ent_s    ent_rd;
    ejs_rec_s    ev_rd;
    ejs_rec_s    rec_q [2];
    logic [1:0]  armed_q;
    logic [1:0]  fire;
    ejs_trav_t   travel_q;
    logic signed [31:0] prod;
    logic [8:0]  nx;
    logic [8:0]  hi_next;
    logic        irq_q;
    logic        running_q;

    wire logic wr_ctrl   = we_in && addr_in == `EJS_OFS_CTRL;
    wire logic wr_stat   = we_in && addr_in == `EJS_OFS_STAT;
    wire logic wr_commit = we_in && addr_in == `EJS_OFS_COMMIT;
    wire logic go        = wr_ctrl && wdata_in[`EJS_CTRL_GO];
    wire logic step      = wr_ctrl && wdata_in[`EJS_CTRL_STEP];
    wire logic halt      = wr_ctrl && wdata_in[`EJS_CTRL_HALT];
    wire logic tick      = tick_cnt_q == 17'(MS_CYC - 1);
    wire logic in_run    = state_q == S_RUN;
    wire logic allow     = ent_q.link != L_NONE || in_loop_in;
    wire logic jump      = in_run && allow && (fire != 2'b00);
    wire logic jsel      = fire[1];
    wire logic [2:0] ev_set = {stop_ev, jump && jsel, jump && !jsel};
    assign hi_next = rec_q[1].next;

    // pins are asynchronous to the sequencer clock
    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            io_s1_q <= '0;
            io_s2_q <= '0;
        end
        else
        begin
            io_s1_q <= io_in;
            io_s2_q <= io_s1_q;
        end
    end

    // staging words reset to the documented field defaults
    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            start_ent_q <= '0;
            mask_q      <= '0;
            taddr_q     <= '0;
            d0_q        <= '0;
            d1_q        <= '0;
            d2_q        <= `EJS_D2_RST;
            e0_q        <= `EJS_E0_RST;
            e1_q        <= `EJS_E1_RST;
        end
        else if (we_in)
        begin
            if (addr_in == `EJS_OFS_CTRL)
                start_ent_q <= wdata_in[`EJS_CTRL_ENT];
            else if (addr_in == `EJS_OFS_MASK)
                mask_q <= wdata_in[2:0];
            else if (addr_in == `EJS_OFS_TADDR)
                taddr_q <= wdata_in[7:0];
            else if (addr_in == `EJS_OFS_D0)
                d0_q <= wdata_in[22:0];
            else if (addr_in == `EJS_OFS_D1)
                d1_q <= wdata_in[22:0];
            else if (addr_in == `EJS_OFS_D2)
                d2_q <= wdata_in[23:0];
            else if (addr_in == `EJS_OFS_E0)
                e0_q <= wdata_in[19:0];
            else if (addr_in == `EJS_OFS_E1)
                e1_q <= wdata_in;
        end
    end

    always_comb
    begin
        rd_mux = '0;
        if (addr_in == `EJS_OFS_CTRL)
            rd_mux = {16'h0, start_ent_q, 8'h0};
        else if (addr_in == `EJS_OFS_STAT)
            rd_mux = {29'h0, stat_q};
        else if (addr_in == `EJS_OFS_MASK)
            rd_mux = {29'h0, mask_q};
        else if (addr_in == `EJS_OFS_STATE)
            rd_mux = {16'h0, cur_q, 3'h0, armed_q, state_q};
        else if (addr_in == `EJS_OFS_TADDR)
            rd_mux = {24'h0, taddr_q};
        else if (addr_in == `EJS_OFS_D0)
            rd_mux = {9'h0, d0_q};
        else if (addr_in == `EJS_OFS_D1)
            rd_mux = {9'h0, d1_q};
        else if (addr_in == `EJS_OFS_D2)
            rd_mux = {8'h0, d2_q};
        else if (addr_in == `EJS_OFS_E0)
            rd_mux = {12'h0, e0_q};
        else if (addr_in == `EJS_OFS_E1)
            rd_mux = e1_q;
    end

    // sticky status: a set in the clearing cycle survives
    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            stat_q  <= '0;
            irq_q   <= 1'b0;
            rdata_q <= '0;
        end
        else
        begin
            stat_q  <= (stat_q & ~(wr_stat ? wdata_in[2:0] : 3'h0)) | ev_set;
            irq_q   <= |(stat_q & mask_q);
            rdata_q <= re_in ? rd_mux : 32'h0;
        end
    end

    ejs_mem_if #(.DW(70), .AW(8)) ent_bus ();
    ejs_mem_if #(.DW(52), .AW(5)) ev_bus ();
    ejs_mem #(.DW(70), .AW(8)) u_ent_mem (.clk_in(ref_clk_in), .bus(ent_bus.mem));
    ejs_mem #(.DW(52), .AW(5)) u_ev_mem (.clk_in(ref_clk_in), .bus(ev_bus.mem));

    assign ent_bus.we    = wr_commit && wdata_in[`EJS_CMT_ENT];
    assign ent_bus.waddr = taddr_q;
    assign ent_bus.wdata = {d2_q, d1_q, d0_q};
    assign ent_bus.raddr = cur_q;
    assign ev_bus.we     = wr_commit && wdata_in[`EJS_CMT_EV];
    assign ev_bus.waddr  = taddr_q[4:0];
    assign ev_bus.wdata  = {e1_q, e0_q};
    // low record read while the entry word arrives, high one after
    assign ev_bus.raddr  = (state_q == S_LDLO) ? ent_rd.lo[4:0] : ent_q.hi[4:0];
    assign ent_rd        = ent_bus.rdata;
    assign ev_rd         = ev_bus.rdata;
    assign prod          = $signed(ent_rd.off) * $signed({1'b0, loop_iter_in});

    // records never committed act as their reset value: disabled
    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            ev_valid_q <= '0;
        else if (ev_bus.we)
            ev_valid_q[taddr_q[4:0]] <= 1'b1;
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            ent_q    <= '0;
            rec_q    <= '{default: '0};
            armed_q  <= '0;
            travel_q <= '0;
        end
        else if (state_q == S_LDLO)
        begin
            ent_q    <= ent_rd;
            travel_q <= ent_rd.base + ((ent_rd.incr && in_loop_in) ? prod[22:0] : 23'h0);
        end
        else if (state_q == S_LDHI)
        begin
            rec_q[0]   <= ev_rd;
            armed_q[0] <= !ent_q.lo[5] && ev_valid_q[ent_q.lo[4:0]];
        end
        else if (state_q == S_ARM)
        begin
            rec_q[1]   <= ev_rd;
            armed_q[1] <= !ent_q.hi[5] && ev_valid_q[ent_q.hi[4:0]];
        end
    end

    // one watcher per event slot, low then high
    for (genvar k = 0; k < 2; k++)
    begin : g_slot
        logic [15:0] cnt_q;
        logic        prev_q;
        wire ejs_typ_e typ = rec_q[k].typ;
        wire logic lvl    = io_s2_q[rec_q[k].sel];
        wire logic edge_t = typ == T_ON_EDGE || typ == T_OFF_EDGE;
        wire logic cum_t  = typ == T_ON_CALC || typ == T_OFF_CALC ||
                            (HAS_CUMUL && (typ == T_ON_CUM || typ == T_OFF_CUM));
        wire logic ok_t   = edge_t || cum_t || typ == T_ON_MS || typ == T_OFF_MS;
        wire logic tgt    = typ == T_ON_CALC || typ == T_ON_MS ||
                            typ == T_ON_EDGE || typ == T_ON_CUM;
        wire logic hit    = lvl == tgt;
        wire logic sat    = cnt_q == 16'hffff;
        assign fire[k] = armed_q[k] && rec_q[k].sel != 5'h0 && ok_t &&
                         (edge_t ? (cnt_q != 16'h0 && cnt_q >= rec_q[k].count)
                                 : (hit && cnt_q >= rec_q[k].count));

        // first run cycle only samples; prev level may be from a stale select
        always_ff @(posedge ref_clk_in or negedge rstn_in)
        begin
            if (!rstn_in)
            begin
                cnt_q  <= '0;
                prev_q <= 1'b0;
            end
            else
            begin
                prev_q <= lvl;
                if (!in_run)
                    cnt_q <= '0;
                else if (!was_run_q)
                    cnt_q <= cnt_q;
                else if (edge_t)
                    cnt_q <= cnt_q + 16'((lvl != prev_q) && hit && !sat);
                else if (!hit && !cum_t)
                    cnt_q <= '0;
                else if (tick && hit)
                    cnt_q <= cnt_q + 16'(!sat);
            end
        end
    end

    function automatic logic [8:0] succ(input logic [8:0] code, input logic [7:0] cur);
        logic [8:0] sum;
        sum = 9'h0;
        if (code == `EJS_NX_STOP)
            succ = {1'b1, cur};
        else if (code == `EJS_NX_P2 || code == `EJS_NX_P1)
        begin
            sum  = {1'b0, cur} + ((code == `EJS_NX_P2) ? 9'h2 : 9'h1);
            succ = sum;
        end
        else if (!code[8])
            succ = {1'b0, code[7:0]};
        else
            succ = {1'b1, cur};
    endfunction

    assign nx = succ(pnext_q, cur_q);

    always_comb
    begin
        state_d = state_q;
        cur_d   = cur_q;
        plink_d = plink_q;
        pnext_d = pnext_q;
        dwell_d = dwell_q;
        start_d = 1'b0;
        abort_d = 1'b0;
        stop_ev = 1'b0;
        case (state_q)
            S_IDLE:
                if (go)
                begin
                    cur_d   = start_ent_q;
                    state_d = S_FETCH;
                end
            S_FETCH: state_d = S_LDLO;
            S_LDLO:  state_d = S_LDHI;
            S_LDHI:  state_d = S_ARM;
            S_ARM:
            begin
                start_d = 1'b1;
                state_d = S_RUN;
            end
            S_RUN:
                if (jump)
                begin
                    abort_d = 1'b1;
                    plink_d = rec_q[jsel].link;
                    pnext_d = rec_q[jsel].next;
                    dwell_d = rec_q[jsel].dwell;
                    state_d = S_DWELL;
                end
                else if (entry_done_in)
                begin
                    plink_d = ent_q.link;
                    pnext_d = ent_q.next;
                    dwell_d = 16'h0;
                    state_d = S_DWELL;
                end
            S_DWELL:
                if (dwell_q != 16'h0)
                begin
                    if (tick)
                        dwell_d = dwell_q - 16'h1;
                end
                else if (nx[8] || plink_q == L_NONE)
                begin
                    stop_ev = 1'b1;
                    state_d = S_IDLE;
                end
                else
                begin
                    cur_d   = nx[7:0];
                    state_d = (plink_q == L_MANUAL) ? S_WAIT : S_FETCH;
                end
            S_WAIT:
                if (step)
                    state_d = S_FETCH;
            default: state_d = S_IDLE;
        endcase
        if (halt && state_q != S_IDLE)
        begin
            stop_ev = 1'b1;
            abort_d = state_q == S_RUN;
            state_d = S_IDLE;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            state_q    <= S_IDLE;
            cur_q      <= '0;
            plink_q    <= L_NONE;
            pnext_q    <= `EJS_NX_STOP;
            dwell_q    <= '0;
            start_q    <= 1'b0;
            abort_q    <= 1'b0;
            was_run_q  <= 1'b0;
            tick_cnt_q <= '0;
            running_q  <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            cur_q      <= cur_d;
            plink_q    <= plink_d;
            pnext_q    <= pnext_d;
            dwell_q    <= dwell_d;
            start_q    <= start_d;
            abort_q    <= abort_d;
            was_run_q  <= in_run;
            running_q  <= state_d != S_IDLE;
            // restart the millisecond grid at entry start and at a jump
            tick_cnt_q <= (tick || start_d || abort_d) ? 17'h0 : tick_cnt_q + 17'h1;
        end
    end

    assign rdata_out       = rdata_q;
    assign entry_no_out    = cur_q;
    assign entry_start_out = start_q;
    assign abort_out       = abort_q;
    assign travel_out      = travel_q;
    assign running_out     = running_q;
    assign irq_out         = irq_q;

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rstn_in);

    property p_hi_prio;
        jump && fire[1] && fire[0] |=> pnext_q == $past(hi_next);
    endproperty
    a_hi_prio: assert property (p_hi_prio) else $error("high event not preferred");

    property p_jump_abort;
        jump && !halt |=> abort_out && state_q == S_DWELL;
    endproperty
    a_jump_abort: assert property (p_jump_abort) else $error("jump did not abort");

    property p_done_next;
        in_run && !jump && !halt && entry_done_in && ent_q.link == L_AUTO &&
        ent_q.next == `EJS_NX_P1 && cur_q != 8'hff && !go
        |-> ##[2:6] entry_start_out;
    endproperty
    a_done_next: assert property (p_done_next) else $error("no successor start");

    property p_nolink_stop;
        state_q == S_DWELL && dwell_q == 16'h0 && plink_q == L_NONE |=> state_q == S_IDLE;
    endproperty
    a_nolink_stop: assert property (p_nolink_stop) else $error("no-link did not stop");

    property p_dwell_hold;
        state_q == S_DWELL && dwell_q != 16'h0 && !halt |=> state_q == S_DWELL;
    endproperty
    a_dwell_hold: assert property (p_dwell_hold) else $error("dwell cut short");

    property p_nosel;
        rec_q[0].sel == 5'h0 || rec_q[0].typ == T_OFF |-> !fire[0];
    endproperty
    a_nosel: assert property (p_nosel) else $error("unused trigger fired");

    property p_cum_rev;
        !HAS_CUMUL && (rec_q[1].typ == T_ON_CUM || rec_q[1].typ == T_OFF_CUM) |-> !fire[1];
    endproperty
    a_cum_rev: assert property (p_cum_rev) else $error("cumulative type in old revision");

    property p_disabled;
        state_q == S_LDHI && ent_q.lo[5] |=> !armed_q[0];
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled event armed");

    property p_succ_p1;
        state_q == S_DWELL && dwell_q == 16'h0 && plink_q == L_AUTO &&
        pnext_q == `EJS_NX_P1 && cur_q != 8'hff && !halt
        |=> cur_q == $past(cur_q) + 8'h1 && state_q == S_FETCH;
    endproperty
    a_succ_p1: assert property (p_succ_p1) else $error("bad successor");

    c_lo_jump: cover property (jump && !fire[1]);
    c_hi_jump: cover property (jump && fire[1] && fire[0]);
    c_manual:  cover property (state_q == S_WAIT ##[1:20] entry_start_out);
endmodule
`default_nettype wire

// ### tb/test_event_jump_sequencer.sv
// self-checking bench of the event jump sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ejs_consts.svh"
module test_event_jump_sequencer;
    import ejs_pkg::*;
    localparam int MS = 10;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        we = 1'b0;
    logic        re = 1'b0;
    logic [31:0] io = 32'h0;
    logic        done = 1'b0;
    logic        loop = 1'b0;
    logic [7:0]  iter = 8'h00;
    logic [31:0] rdata;
    logic [7:0]  ent_no;
    logic        start, abort, running, irq;
    ejs_trav_t   travel;
    int          err_total = 0;
    int          tests_run = 0;
    logic [31:0] seed = 32'd13967;

    ejs_top #(.MS_CYC(MS), .HAS_CUMUL(1'b1)) uut (.ref_clk_in(clk), .rstn_in(rstn),
        .addr_in(addr), .wdata_in(wdata), .we_in(we), .re_in(re), .rdata_out(rdata),
        .io_in(io), .entry_done_in(done), .in_loop_in(loop), .loop_iter_in(iter),
        .entry_no_out(ent_no), .entry_start_out(start), .abort_out(abort),
        .travel_out(travel), .running_out(running), .irq_out(irq));

    always #5 clk = ~clk;

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // loop offset scales with passes, wraps in 23 bits like the travel port
    function automatic logic [22:0] trav_exp(input logic [22:0] b, o, input logic [7:0] n);
        return b + o * {15'h0, n};
    endfunction

    task automatic final_report();
        $display("mismatches %0d checks %0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        we <= 1'b1;
        @(posedge clk);
        we <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        re <= 1'b1;
        @(posedge clk);
        re <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic pulse_done();
        @(posedge clk);
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
    endtask

    // w: 0 entry start, 1 abort, 2 back to idle; bounded so a hang shows as a mismatch
    task automatic wait_for(input int w, output int n);
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end
        while (n < 300 && !(w == 0 ? start === 1'b1 : w == 1 ? abort === 1'b1 : running === 1'b0));
        if (n >= 300)
            chk(32'h0, 32'h1);
    endtask

    initial
    begin
        #100000;
        err_total++;
        final_report();
    end

    initial
    begin
        int n;
        logic [22:0] base, off;
        logic [4:0]  b0, b1;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        base = 23'(xs() & 32'hffff);
        off = 23'(xs() & 32'hfff);
        b0 = 5'(1 + xs() % 15);
        b1 = 5'(16 + xs() % 15);
        iter <= 8'(1 + xs() % 5);
        loop <= 1'b1;
        rd(`EJS_OFS_MASK, 32'h0);
        rd(`EJS_OFS_STATE, 32'h0);
        rd(8'hfc, 32'h0);
        wr(`EJS_OFS_MASK, 32'h7);
        for (int r = 0; r < 2; r++)
        begin
            wr(`EJS_OFS_TADDR, 32'(r));
            wr(`EJS_OFS_E0, {12'h0, 4'h5, (r == 1 ? b1 : b0), 9'(2 + r), 2'b10});
            wr(`EJS_OFS_E1, {16'h1, 16'h1});
            wr(`EJS_OFS_COMMIT, 32'h2);
        end
        for (int e = 0; e < 4; e++)
        begin
            wr(`EJS_OFS_TADDR, 32'(e));
            wr(`EJS_OFS_D0, {9'h0, base});
            wr(`EJS_OFS_D1, {9'h0, off});
            wr(`EJS_OFS_D2, e == 0 ? {8'h0, 1'b1, 6'd1, 6'd0, 9'h1ff, 2'b10}
                                   : {8'h0, 1'b0, 6'h3f, 6'h3f, 9'h1ff, 2'b00});
            wr(`EJS_OFS_COMMIT, 32'h1);
        end
        // quiet io: entry 0 completes, auto link moves on, entry 1 has no link
        wr(`EJS_OFS_CTRL, 32'h1);
        wait_for(0, n);
        chk(32'(ent_no), 32'h0);
        chk(32'(travel), 32'(trav_exp(base, off, iter)));
        pulse_done();
        wait_for(0, n);
        chk(32'(ent_no), 32'h1);
        chk(32'(travel), 32'(base));
        pulse_done();
        wait_for(2, n);
        rd(`EJS_OFS_STAT, 32'h4);
        chk(32'(irq), 32'h1);
        wr(`EJS_OFS_STAT, 32'h7);
        repeat (2) @(posedge clk);
        #1;
        chk(32'(irq), 32'h0);
        // k=0 both events fire together, k=1 only the low event
        for (int k = 0; k < 2; k++)
        begin
            @(posedge clk);
            io <= 32'h0;
            repeat (4) @(posedge clk);
            wr(`EJS_OFS_CTRL, 32'h1);
            wait_for(0, n);
            repeat (3) @(posedge clk);
            io <= (32'h1 << b0) | (k == 0 ? 32'h1 << b1 : 32'h0);
            wait_for(1, n);
            wait_for(0, n);
            chk(32'(n >= MS), 32'h1);
            chk(32'(ent_no), k == 0 ? 32'h3 : 32'h2);
            pulse_done();
            wait_for(2, n);
            rd(`EJS_OFS_STAT, k == 0 ? 32'h6 : 32'h5);
            wr(`EJS_OFS_STAT, 32'h7);
        end
        // high event alone on a 2 ms level; manual link then waits for step
        wr(`EJS_OFS_TADDR, 32'h1);
        wr(`EJS_OFS_E0, {12'h0, 4'h2, b1, 9'h2, 2'b01});
        wr(`EJS_OFS_E1, {16'h2, 16'h0});
        wr(`EJS_OFS_COMMIT, 32'h2);
        @(posedge clk);
        io <= 32'h0;
        wr(`EJS_OFS_CTRL, 32'h1);
        wait_for(0, n);
        @(posedge clk);
        io <= 32'h1 << b1;
        wait_for(1, n);
        chk(32'(n > MS && n <= 3 * MS), 32'h1);
        repeat (4) @(posedge clk);
        #1;
        chk(32'({start, running}), 32'h1);
        wr(`EJS_OFS_CTRL, 32'h2);
        wait_for(0, n);
        chk(32'(ent_no), 32'h2);
        // halt while the entry runs: abort pulse and stop flag
        wr(`EJS_OFS_CTRL, 32'h4);
        #1;
        chk(32'(abort), 32'h1);
        wait_for(2, n);
        rd(`EJS_OFS_STAT, 32'h6);
        final_report();
    end
endmodule
`default_nettype wire
